// ---- logic/gp_regfile_pkg.sv ----
/*
 Package for the dual-bank general-purpose register file: sizes, pair
 layout, long-value field split and unit numbering.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package gp_regfile_pkg;
    // ========================================================================
    // Sizes
    localparam int BASE_REGS   = 16;       // Registers per bank, base core
    localparam int EXT_REGS    = 32;       // Registers per bank, extended core
    localparam int WORD_W      = 32;       // Register width
    localparam int LONG_HI_W   = 8;        // High part of a 40-bit long
    localparam int LONG_W      = 40;
    localparam int DWORD_W     = 64;
    localparam int UNITS_SIDE  = 4;        // Functional units per data path
    localparam int ADDR_W      = 5;        // Register index width (max bank)
    localparam int CTRL_ADDR_W = 5;        // Control register index width

    // ========================================================================
    // Unit numbering inside one side
    localparam logic [1:0] UNIT_LOGIC = 2'h0;
    localparam logic [1:0] UNIT_SHIFT = 2'h1;  // Shift/branch unit
    localparam logic [1:0] UNIT_MUL   = 2'h2;
    localparam logic [1:0] UNIT_DATA  = 2'h3;
    localparam logic       SIDE_FIRST  = 1'h0;
    localparam logic       SIDE_SECOND = 1'h1;

    // Write width of a result
    typedef enum logic [1:0] {
        WR_WORD,
        WR_LONG,
        WR_DWORD
    } wr_size_t;

    // Pair partner: even index with bit 0 forced, plus one
    function automatic logic [ADDR_W-1:0] pair_odd(input logic [ADDR_W-1:0] ev);
        pair_odd = {ev[ADDR_W-1:1], 1'h1};
    endfunction : pair_odd

    function automatic logic [ADDR_W-1:0] pair_even(input logic [ADDR_W-1:0] ev);
        pair_even = {ev[ADDR_W-1:1], 1'h0};
    endfunction : pair_even
endpackage : gp_regfile_pkg

// ---- logic/gp_bank.sv ----
/*
 One general-purpose register bank: per-unit 32-bit write ports with an
 optional odd-register write for wide results, and per-unit read ports
 returning a word and its pair partner from the same storage snapshot.
 Assumes writers of one bank never target one register in the same cycle.
*/
`timescale 1ns/1ps
module gp_bank
    import gp_regfile_pkg::*;
#(
    parameter int NREGS = BASE_REGS
) (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              srst,
    // Write ports, one per unit of this side
    input  wire logic [UNITS_SIDE-1:0]             wrEn,
    input  wire wr_size_t [UNITS_SIDE-1:0]         wrSize,
    input  wire logic [UNITS_SIDE-1:0][ADDR_W-1:0] wrAddr,
    input  wire logic [UNITS_SIDE-1:0][DWORD_W-1:0] wrData,
    // Read ports, two sources per unit
    input  wire logic [2*UNITS_SIDE-1:0][ADDR_W-1:0] rdAddr,
    output logic [2*UNITS_SIDE-1:0][WORD_W-1:0]      rdLo,
    output logic [2*UNITS_SIDE-1:0][WORD_W-1:0]      rdHi
);
    // ========================================================================
    // Storage
    logic [WORD_W-1:0] regs_r [NREGS];

    // Elaboration refuses bank sizes the pair and index logic cannot serve
    if (NREGS != BASE_REGS && NREGS != EXT_REGS) begin : g_bad_depth
        $error("gp_bank: NREGS must be 16 or 32");
    end

    // Odd-register value for each write size; a long zero-fills the top 24 bits
    function automatic logic [WORD_W-1:0] hi_word(input wr_size_t sz,
                                                  input logic [DWORD_W-1:0] d);
        hi_word = (sz == WR_LONG) ?
            {{(WORD_W-LONG_HI_W){1'b0}}, d[WORD_W +: LONG_HI_W]} :
            d[WORD_W +: WORD_W];
    endfunction : hi_word

    // Writes land at the clock edge; later units win on a clash
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < NREGS; i++) regs_r[i] <= '0;
        end else begin
            for (int u = 0; u < UNITS_SIDE; u++) begin
                if (wrEn[u] && wrSize[u] == WR_WORD)
                    regs_r[wrAddr[u] % NREGS] <= wrData[u][WORD_W-1:0];
                else if (wrEn[u]) begin
                    // Pair written by its even member
                    regs_r[pair_even(wrAddr[u]) % NREGS] <= wrData[u][WORD_W-1:0];
                    regs_r[pair_odd(wrAddr[u]) % NREGS]  <= hi_word(wrSize[u], wrData[u]);
                end
            end
        end
    end

    // Both halves come from the same combinational snapshot of storage
    always_comb begin
        for (int p = 0; p < 2*UNITS_SIDE; p++) begin
            rdLo[p] = regs_r[rdAddr[p] % NREGS];
            rdHi[p] = regs_r[pair_odd(rdAddr[p]) % NREGS];
        end
    end
endmodule : gp_bank

// ---- logic/dual_bank_gp_register_file.sv ----
/*
 Dual-bank general-purpose register file for a two-path VLIW core.
 Each side has four units; each unit owns a write port into its own bank
 and two source read ports, giving word, long, double and packed views.
 Assumes decode hands over register indices and write sizes already.
// How it works
// - Base core: two banks of sixteen words
// - Extended core: banks of thirty-two words
// - Any register serves data, address or predicate
// - Wide value: low even, high next odd
// - Only even/odd adjacent pairs form wide operands
// - Long read ignores odd register top bits
// - Long write zero-fills odd register top bits
// - Pair named by even index, odd derived
// - Packed bytes, halves, and four halves per pair
// - Extended: packed bytes, 64-bit fixed; no float
// - Eight units, two matched groups of four
// - Only second-side shift unit moves control registers
// - Each side writes only its own bank
*/
`timescale 1ns/1ps
module dual_bank_gp_register_file
    import gp_regfile_pkg::*;
#(
    parameter bit EXTENDED = 1'b0
) (
    // Clock and reset
    input  wire logic                                     mclk,
    input  wire logic                                     srst,
    // First side unit writes
    input  wire logic [UNITS_SIDE-1:0]                    firstWrEn,
    input  wire wr_size_t [UNITS_SIDE-1:0]                firstWrSize,
    input  wire logic [UNITS_SIDE-1:0][ADDR_W-1:0]        firstWrAddr,
    input  wire logic [UNITS_SIDE-1:0][DWORD_W-1:0]       firstWrData,
    // Second side unit writes
    input  wire logic [UNITS_SIDE-1:0]                    secondWrEn,
    input  wire wr_size_t [UNITS_SIDE-1:0]                secondWrSize,
    input  wire logic [UNITS_SIDE-1:0][ADDR_W-1:0]        secondWrAddr,
    input  wire logic [UNITS_SIDE-1:0][DWORD_W-1:0]       secondWrData,
    // Source reads, two per unit
    input  wire logic [2*UNITS_SIDE-1:0][ADDR_W-1:0]      firstRdAddr,
    input  wire logic [2*UNITS_SIDE-1:0][ADDR_W-1:0]      secondRdAddr,
    output logic [2*UNITS_SIDE-1:0][WORD_W-1:0]           firstRdWord,
    output logic [2*UNITS_SIDE-1:0][WORD_W-1:0]           secondRdWord,
    output logic [2*UNITS_SIDE-1:0][LONG_W-1:0]           firstRdLong,
    output logic [2*UNITS_SIDE-1:0][LONG_W-1:0]           secondRdLong,
    output logic [2*UNITS_SIDE-1:0][DWORD_W-1:0]          firstRdDword,
    output logic [2*UNITS_SIDE-1:0][DWORD_W-1:0]          secondRdDword,
    output logic [2*UNITS_SIDE-1:0]                       firstRdPredTrue,
    output logic [2*UNITS_SIDE-1:0]                       secondRdPredTrue,
    output logic [2*UNITS_SIDE-1:0]                       firstRdPairOk,
    output logic [2*UNITS_SIDE-1:0]                       secondRdPairOk,
    // Control register moves, shift/branch unit of the second side only
    input  wire logic                                     ctrlMoveReq,
    input  wire logic                                     ctrlMoveSide,
    input  wire logic [1:0]                               ctrlMoveUnit,
    input  wire logic                                     ctrlMoveToCtrl,
    input  wire logic [ADDR_W-1:0]                        ctrlMoveGpAddr,
    input  wire logic [CTRL_ADDR_W-1:0]                   ctrlMoveCtrlAddr,
    input  wire logic [WORD_W-1:0]                        ctrlRdData,
    output logic                                          ctrlWrEn,
    output logic [CTRL_ADDR_W-1:0]                        ctrlWrAddr,
    output logic [WORD_W-1:0]                             ctrlWrData,
    output logic                                          ctrlMoveReject,
    // Variant and access checks
    output logic [ADDR_W:0]                               bankDepth,
    output logic                                          floatSupport
);
    // ========================================================================
    // Variant sizing
    localparam int NREGS = EXTENDED ? EXT_REGS : BASE_REGS;

    // Bank depth and the fact that no float path exists
    assign bankDepth    = (ADDR_W+1)'(NREGS);
    assign floatSupport = 1'b0;

    // ========================================================================
    // Control register move qualification
    // Only the second-side shift/branch unit may move; anything else is refused
    wire moveAllowed = ctrlMoveReq && ctrlMoveSide == SIDE_SECOND
                       && ctrlMoveUnit == UNIT_SHIFT;
    wire moveToGp    = moveAllowed && !ctrlMoveToCtrl;
    wire moveToCtrl  = moveAllowed && ctrlMoveToCtrl;

    // The move into a general register takes the shift unit's write port
    logic [UNITS_SIDE-1:0]              secWrEnEff;
    wr_size_t [UNITS_SIDE-1:0]          secWrSizeEff;
    logic [UNITS_SIDE-1:0][ADDR_W-1:0]  secWrAddrEff;
    logic [UNITS_SIDE-1:0][DWORD_W-1:0] secWrDataEff;

    always_comb begin
        secWrEnEff   = secondWrEn;
        secWrSizeEff = secondWrSize;
        secWrAddrEff = secondWrAddr;
        secWrDataEff = secondWrData;
        if (moveToGp) begin
            secWrEnEff[UNIT_SHIFT]   = 1'b1;
            secWrSizeEff[UNIT_SHIFT] = WR_WORD;
            secWrAddrEff[UNIT_SHIFT] = ctrlMoveGpAddr;
            secWrDataEff[UNIT_SHIFT] = {{(DWORD_W-WORD_W){1'b0}}, ctrlRdData};
        end
    end

    // ========================================================================
    // Raw bank read halves, declared ahead of the instances that drive them
    logic [2*UNITS_SIDE-1:0][WORD_W-1:0] firstLo;
    logic [2*UNITS_SIDE-1:0][WORD_W-1:0] firstHi;
    logic [2*UNITS_SIDE-1:0][WORD_W-1:0] secondLo;
    logic [2*UNITS_SIDE-1:0][WORD_W-1:0] secondHi;

    // Banks: each side's units reach only their own bank
    gp_bank #(.NREGS(NREGS)) firstBank (
        .mclk   (mclk),
        .srst   (srst),
        .wrEn   (firstWrEn),
        .wrSize (firstWrSize),
        .wrAddr (firstWrAddr),
        .wrData (firstWrData),
        .rdAddr (firstRdAddr),
        .rdLo   (firstLo),
        .rdHi   (firstHi)
    );

    gp_bank #(.NREGS(NREGS)) secondBank (
        .mclk   (mclk),
        .srst   (srst),
        .wrEn   (secWrEnEff),
        .wrSize (secWrSizeEff),
        .wrAddr (secWrAddrEff),
        .wrData (secWrDataEff),
        .rdAddr (secondRdAddr),
        .rdLo   (secondLo),
        .rdHi   (secondHi)
    );

    // ========================================================================
    // Operand views; packed lanes are just slices of the word or pair
    function automatic logic pair_ok(input logic [ADDR_W-1:0] a);
        pair_ok = !a[0] && (int'(a) < NREGS);
    endfunction : pair_ok

    always_comb begin
        for (int p = 0; p < 2*UNITS_SIDE; p++) begin
            firstRdWord[p]  = firstLo[p];
            secondRdWord[p] = secondLo[p];
            firstRdLong[p]  = {firstHi[p][LONG_HI_W-1:0], firstLo[p]};
            secondRdLong[p] = {secondHi[p][LONG_HI_W-1:0], secondLo[p]};
            firstRdDword[p]  = {firstHi[p], firstLo[p]};
            secondRdDword[p] = {secondHi[p], secondLo[p]};
            firstRdPredTrue[p]  = |firstLo[p];
            secondRdPredTrue[p] = |secondLo[p];
            firstRdPairOk[p]  = pair_ok(firstRdAddr[p]);
            secondRdPairOk[p] = pair_ok(secondRdAddr[p]);
        end
    end

    // ========================================================================
    // Control register write-back, registered to meet the output style
    logic                    ctrlWrEn_r;
    logic [CTRL_ADDR_W-1:0]  ctrlWrAddr_r;
    logic [WORD_W-1:0]       ctrlWrData_r;
    logic                    ctrlMoveReject_r;
    wire  [WORD_W-1:0]       moveSrc = secondBank.regs_r[ctrlMoveGpAddr % NREGS];

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlWrEn_r       <= 1'b0;
            ctrlWrAddr_r     <= '0;
            ctrlWrData_r     <= '0;
            ctrlMoveReject_r <= 1'b0;
        end else begin
            ctrlWrEn_r       <= moveToCtrl;
            ctrlWrAddr_r     <= ctrlMoveCtrlAddr;
            ctrlWrData_r     <= moveSrc;
            ctrlMoveReject_r <= ctrlMoveReq && !moveAllowed;
        end
    end

    assign ctrlWrEn       = ctrlWrEn_r;
    assign ctrlWrAddr     = ctrlWrAddr_r;
    assign ctrlWrData     = ctrlWrData_r;
    assign ctrlMoveReject = ctrlMoveReject_r;

    // ========================================================================
    // Checks
    // A control write-back must trace to the second-side shift unit
    a_move_only_shift: assert property (@(posedge mclk) disable iff (srst)
        ctrlWrEn |-> $past(ctrlMoveSide) == SIDE_SECOND && $past(ctrlMoveUnit) == UNIT_SHIFT)
        else $error("control move from wrong unit");

    // A first-side request is refused and never reaches the control file
    a_move_reject: assert property (@(posedge mclk) disable iff (srst)
        ctrlMoveReq && ctrlMoveSide == SIDE_FIRST |=> ctrlMoveReject && !ctrlWrEn)
        else $error("first side move not refused");

    // A lone long write leaves the odd register's top bits clear
    a_long_zero_hi: assert property (@(posedge mclk) disable iff (srst)
        firstWrEn == 4'h1 && firstWrSize[0] == WR_LONG
        |=> firstBank.regs_r[$past(pair_odd(firstWrAddr[0])) % NREGS][WORD_W-1:LONG_HI_W] == '0)
        else $error("long write left high bits");

    // A long read takes only the odd register's low byte as its top
    a_long_ignore: assert property (@(posedge mclk) disable iff (srst)
        firstRdLong[1][LONG_W-1:WORD_W]
        == firstBank.regs_r[pair_odd(firstRdAddr[1]) % NREGS][LONG_HI_W-1:0])
        else $error("long read wrong high byte");

    // A lone second-side word lands at its index
    a_word_store: assert property (@(posedge mclk) disable iff (srst)
        secondWrEn == 4'h1 && secondWrSize[0] == WR_WORD && !moveToGp
        |=> secondBank.regs_r[$past(secondWrAddr[0]) % NREGS]
            == $past(secondWrData[0][WORD_W-1:0]))
        else $error("word write lost");

    // Only even indices inside the bank may name a pair
    a_pair_odd: assert property (@(posedge mclk) disable iff (srst)
        firstRdPairOk[2] |-> !firstRdAddr[2][0] && int'(firstRdAddr[2]) < NREGS)
        else $error("odd index accepted as pair");

    // A lone double fills both the even and the odd member
    a_dword_store: assert property (@(posedge mclk) disable iff (srst)
        firstWrEn == 4'h4 && firstWrSize[2] == WR_DWORD
        |=> {firstBank.regs_r[$past(pair_odd(firstWrAddr[2])) % NREGS],
             firstBank.regs_r[$past(pair_even(firstWrAddr[2])) % NREGS]}
            == $past(firstWrData[2]))
        else $error("double write not paired");

    // First-side writes leave the second bank untouched
    a_side_isolate: assert property (@(posedge mclk) disable iff (srst)
        firstWrEn != '0 && secondWrEn == '0 && !moveToGp
        |=> $stable(secondLo))
        else $error("first side wrote second bank");

    // The variant flags stay fixed
    a_no_float: assert property (@(posedge mclk) disable iff (srst)
        !floatSupport && bankDepth == (ADDR_W+1)'(NREGS))
        else $error("variant flags wrong");

    // A granted move into a general register lands there one edge later
    a_move_gp_lands: assert property (@(posedge mclk) disable iff (srst)
        moveToGp && secondWrEn[UNIT_DATA:UNIT_MUL] == '0
        |=> secondBank.regs_r[$past(ctrlMoveGpAddr) % NREGS] == $past(ctrlRdData))
        else $error("move to general register lost");

    // The predicate is true exactly for a nonzero stored word
    a_pred_word: assert property (@(posedge mclk) disable iff (srst)
        secondRdPredTrue[4] == (secondBank.regs_r[secondRdAddr[4] % NREGS] != '0))
        else $error("predicate differs from word");

    // Both halves of a double come from one cycle's storage
    a_pair_snapshot: assert property (@(posedge mclk) disable iff (srst)
        firstRdDword[5] == {firstBank.regs_r[pair_odd(firstRdAddr[5]) % NREGS],
                            firstBank.regs_r[firstRdAddr[5] % NREGS]})
        else $error("double read mixes cycles");

    // Main scenarios seen at least once
    c_move_ok:  cover property (@(posedge mclk) ctrlWrEn);
    c_move_bad: cover property (@(posedge mclk) ctrlMoveReject);
    c_move_gp:  cover property (@(posedge mclk) moveToGp);
    c_long_wr:  cover property (@(posedge mclk) firstWrEn[0] && firstWrSize[0] == WR_LONG);
    c_dword_wr: cover property (@(posedge mclk) firstWrEn == 4'h4 && firstWrSize[2] == WR_DWORD);
endmodule : dual_bank_gp_register_file

// ---- testbench/fu_partner.sv ----
/*
 Functional-unit writer model for both data paths of the register file.
 Assumes the bench calls its tasks just after a rising edge of mclk.
*/
`timescale 1ns/1ps
module fu_partner
    import gp_regfile_pkg::*;
(
    // Write ports, index 0 is the first side, 1 the second side
    output logic [1:0][UNITS_SIDE-1:0]               wrEn,
    output wr_size_t [1:0][UNITS_SIDE-1:0]           wrSize,
    output logic [1:0][UNITS_SIDE-1:0][ADDR_W-1:0]   wrAddr,
    output logic [1:0][UNITS_SIDE-1:0][DWORD_W-1:0]  wrData
);
    // ========================================================================
    // Idle values at time zero
    initial begin
        wrEn   = '0;
        wrAddr = '0;
        wrData = '0;
        for (int s = 0; s < 2; s++) begin
            for (int u = 0; u < UNITS_SIDE; u++) begin
                wrSize[s][u] = WR_WORD;
            end
        end
    end

    // One unit result, held until release_all at a later edge
    task automatic put(input int s, input int u, input wr_size_t z,
                       input logic [ADDR_W-1:0] a, input logic [DWORD_W-1:0] d);
        wrEn[s][u]   <= 1'b1;
        wrSize[s][u] <= z;
        wrAddr[s][u] <= a;
        wrData[s][u] <= d;
    endtask : put

    // Released address and data lines flip, so a stale value is never mistaken for fresh data
    task automatic release_all();
        wrEn   <= '0;
        wrAddr <= ~wrAddr;
        wrData <= ~wrData;
    endtask : release_all
endmodule : fu_partner

// ---- testbench/testbench.sv ----
/*
 Self-checking bench for the dual-bank register file, base and extended variants.
 Assumes the design's own assertions guard timing; this compares values.
*/
`timescale 1ns/1ps
module testbench
    import gp_regfile_pkg::*;
;
    // ========================================================================
    // Signals
    logic                                          mclk = 1'b0;
    logic                                          srst = 1'b1;
    logic [1:0][UNITS_SIDE-1:0]                    wEn;
    wr_size_t [1:0][UNITS_SIDE-1:0]                wSz;
    logic [1:0][UNITS_SIDE-1:0][ADDR_W-1:0]        wAd;
    logic [1:0][UNITS_SIDE-1:0][DWORD_W-1:0]       wDa;
    logic [1:0][2*UNITS_SIDE-1:0][ADDR_W-1:0]      rdAd = '0;
    logic [1:0][2*UNITS_SIDE-1:0][WORD_W-1:0]      rdW;
    logic [1:0][2*UNITS_SIDE-1:0][LONG_W-1:0]      rdL;
    logic [1:0][2*UNITS_SIDE-1:0][DWORD_W-1:0]     rdD;
    logic [1:0][2*UNITS_SIDE-1:0]                  rdP;
    logic [1:0][2*UNITS_SIDE-1:0]                  rdOk;
    logic                                          mvReq = 1'b0;
    logic                                          mvSide = 1'b0;
    logic [1:0]                                    mvUnit = 2'h0;
    logic                                          mvToC = 1'b0;
    logic [ADDR_W-1:0]                             mvGp = '0;
    logic [CTRL_ADDR_W-1:0]                        mvCa = '0;
    logic [WORD_W-1:0]                             cRd = '0;
    logic                                          cWrEn;
    logic [CTRL_ADDR_W-1:0]                        cWrAd;
    logic [WORD_W-1:0]                             cWrDa;
    logic                                          cRej;
    logic [ADDR_W:0]                               depth;
    logic                                          fpOn;
    logic [1:0][2*UNITS_SIDE-1:0][WORD_W-1:0]      rdWX;
    logic [ADDR_W:0]                               depthX;
    logic [31:0]                                   mdl [2][16];
    int                                            miscompares = 0;
    int                                            compares = 0;

    // Clock, 100 ns period
    always #50 mclk = ~mclk;

    fu_partner pu (.wrEn(wEn), .wrSize(wSz), .wrAddr(wAd), .wrData(wDa));

    dual_bank_gp_register_file #(.EXTENDED(1'b0)) dut_u (
        .mclk(mclk), .srst(srst),
        .firstWrEn(wEn[0]), .firstWrSize(wSz[0]), .firstWrAddr(wAd[0]),
        .firstWrData(wDa[0]), .secondWrEn(wEn[1]), .secondWrSize(wSz[1]),
        .secondWrAddr(wAd[1]), .secondWrData(wDa[1]),
        .firstRdAddr(rdAd[0]), .secondRdAddr(rdAd[1]),
        .firstRdWord(rdW[0]), .secondRdWord(rdW[1]),
        .firstRdLong(rdL[0]), .secondRdLong(rdL[1]),
        .firstRdDword(rdD[0]), .secondRdDword(rdD[1]),
        .firstRdPredTrue(rdP[0]), .secondRdPredTrue(rdP[1]),
        .firstRdPairOk(rdOk[0]), .secondRdPairOk(rdOk[1]),
        .ctrlMoveReq(mvReq), .ctrlMoveSide(mvSide), .ctrlMoveUnit(mvUnit),
        .ctrlMoveToCtrl(mvToC), .ctrlMoveGpAddr(mvGp), .ctrlMoveCtrlAddr(mvCa),
        .ctrlRdData(cRd), .ctrlWrEn(cWrEn), .ctrlWrAddr(cWrAd),
        .ctrlWrData(cWrDa), .ctrlMoveReject(cRej),
        .bankDepth(depth), .floatSupport(fpOn));

    // Extended variant on the same traffic; low indices must agree
    dual_bank_gp_register_file #(.EXTENDED(1'b1)) dutExt (
        .mclk(mclk), .srst(srst),
        .firstWrEn(wEn[0]), .firstWrSize(wSz[0]), .firstWrAddr(wAd[0]),
        .firstWrData(wDa[0]), .secondWrEn(wEn[1]), .secondWrSize(wSz[1]),
        .secondWrAddr(wAd[1]), .secondWrData(wDa[1]),
        .firstRdAddr(rdAd[0]), .secondRdAddr(rdAd[1]),
        .firstRdWord(rdWX[0]), .secondRdWord(rdWX[1]),
        .firstRdLong(), .secondRdLong(), .firstRdDword(), .secondRdDword(),
        .firstRdPredTrue(), .secondRdPredTrue(), .firstRdPairOk(), .secondRdPairOk(),
        .ctrlMoveReq(mvReq), .ctrlMoveSide(mvSide), .ctrlMoveUnit(mvUnit),
        .ctrlMoveToCtrl(mvToC), .ctrlMoveGpAddr(mvGp), .ctrlMoveCtrlAddr(mvCa),
        .ctrlRdData(cRd), .ctrlWrEn(), .ctrlWrAddr(), .ctrlWrData(),
        .ctrlMoveReject(), .bankDepth(depthX), .floatSupport());

    // ========================================================================
    // Checking tasks
    task automatic cmp(input string n, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
        end
    endtask : cmp

    // Read one register through a port picked from its index
    task automatic checkReg(input int s, input int i);
        int p;
        logic [31:0] lo;
        logic [31:0] hi;
        p = i % 8;
        lo = mdl[s][i];
        hi = mdl[s][i | 1];
        @(posedge mclk);
        rdAd[s][p] <= 5'(i);
        @(negedge mclk);
        cmp("word", rdW[s][p], lo);
        cmp("wordx", rdWX[s][p], lo);
        cmp("pred", rdP[s][p], lo != 32'h0);
        cmp("long", rdL[s][p], {hi[7:0], lo});
        cmp("dword", rdD[s][p], {hi, lo});
        cmp("pairok", rdOk[s][p], (i % 2) == 0);
    endtask : checkReg

    task automatic checkAll();
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < BASE_REGS; i++) begin
                checkReg(s, i);
            end
        end
    endtask : checkAll

    // One move request; only the second-side shift unit may act
    task automatic move(input int s, input int u, input bit toC, input int gp);
        logic [31:0] cd;
        logic [4:0] ca;
        bit ok;
        cd = $urandom;
        ca = 5'($urandom);
        ok = (s == 1) && (u == 1);
        @(posedge mclk);
        mvReq <= 1'b1;
        mvSide <= 1'(s);
        mvUnit <= 2'(u);
        mvToC <= toC;
        mvGp <= 5'(gp);
        mvCa <= ca;
        cRd <= cd;
        @(posedge mclk);
        mvReq <= 1'b0;
        cRd <= ~cd;
        @(negedge mclk);
        cmp("reject", cRej, !ok);
        cmp("ctrlwren", cWrEn, ok && toC);
        if (ok && toC) begin
            cmp("ctrladdr", cWrAd, ca);
            cmp("ctrldata", cWrDa, mdl[1][gp]);
        end
        if (ok && !toC) mdl[1][gp] = cd;
    endtask : move

    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // ========================================================================
    // Main sequence
    initial begin
        int i;
        logic [31:0] v;
        logic [63:0] d;
        void'($urandom(47));
        for (int s = 0; s < 2; s++) for (int k = 0; k < 16; k++) mdl[s][k] = 32'h0;
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        cmp("depth", depth, 16);
        cmp("float", fpOn, 0);
        cmp("depthx", depthX, 32);
        checkAll();
        $display("test reset done");
        // Every unit of both sides writes its own bank in the same cycle
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            for (int s = 0; s < 2; s++) for (int u = 0; u < 4; u++) begin
                i = 4 * u + $urandom_range(3);
                v = ($urandom_range(3) == 0) ? 32'h0 : $urandom;
                pu.put(s, u, WR_WORD, 5'(i), {$urandom, v});
                mdl[s][i] = v;
            end
            @(posedge mclk);
            pu.release_all();
        end
        checkAll();
        $display("test word writes done");
        // Long to pair 4u named by its odd member, then a double to 4u+2
        @(posedge mclk);
        for (int s = 0; s < 2; s++) for (int u = 0; u < 4; u++) begin
            d = {$urandom, $urandom};
            pu.put(s, u, WR_LONG, 5'(4 * u + 1), d);
            mdl[s][4 * u] = d[31:0];
            mdl[s][4 * u + 1] = {24'h0, d[39:32]};
        end
        @(posedge mclk);
        for (int s = 0; s < 2; s++) for (int u = 0; u < 4; u++) begin
            d = {$urandom, $urandom};
            pu.put(s, u, WR_DWORD, 5'(4 * u + 2), d);
            mdl[s][4 * u + 2] = d[31:0];
            mdl[s][4 * u + 3] = d[63:32];
        end
        @(posedge mclk);
        pu.release_all();
        checkAll();
        $display("test pair writes done");
        // Lone writers, so each store check sees one unit in its bank
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            d = {$urandom, $urandom};
            i = 2 * $urandom_range(7);
            if (k == 0) pu.put(0, 0, WR_LONG, 5'(i), d);
            if (k == 1) pu.put(0, 2, WR_DWORD, 5'(i), d);
            if (k == 2) pu.put(1, 0, WR_WORD, 5'(i), d);
            mdl[k / 2][i] = d[31:0];
            if (k == 0) mdl[0][i + 1] = {24'h0, d[39:32]};
            if (k == 1) mdl[0][i + 1] = d[63:32];
            @(posedge mclk);
            pu.release_all();
        end
        checkAll();
        $display("test lone writes done");
        // Every unit asks for moves both ways
        for (int s = 0; s < 2; s++) for (int u = 0; u < 4; u++) begin
            move(s, u, 1'b1, $urandom_range(15));
            move(s, u, 1'b0, $urandom_range(15));
        end
        checkAll();
        $display("test control moves done");
        give_verdict();
    end

    // Watchdog, well beyond the few hundred cycles the tests take
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end
endmodule : testbench
